// [hdl/shp_defs.vh]
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH

// ==========================================================================
// Serial frame layout, counted in serial clock rising edges.
// ==========================================================================
`define SHP_FRAME_BITS      5'd16
`define SHP_ADDR_LAST_BIT   5'd6
`define SHP_DUMMY_BIT       5'd7
`define SHP_DATA_FIRST_BIT  5'd8
`define SHP_DATA_LAST_BIT   5'd15
`define SHP_ADDR_WIDTH      6
`define SHP_DATA_WIDTH      8

// ==========================================================================
// Read/write flag encoding in the first frame bit.
// ==========================================================================
`define SHP_RW_READ         1'b1

// ==========================================================================
// Address range whose reading acknowledges the alarm interrupt.
// ==========================================================================
`define SHP_STATUS_ADDR_LO  6'h20
`define SHP_STATUS_ADDR_HI  6'h27

// ==========================================================================
// Synchroniser reset values: select and serial clock start at their idle
// high levels, so leaving reset never looks like a clock edge.
// ==========================================================================
`define SHP_SYNC_RESET      4'hb

`endif

// [hdl/shp_sync.v]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Two-stage synchroniser for a group of independent level inputs.
// ==========================================================================
module shp_sync #(
  parameter       WIDTH     = 4,
  parameter [3:0] RESET_VAL = 4'h0
) (
  input  wire             clock_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // The first stage feeds only the second, to keep metastability contained.
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= RESET_VAL[WIDTH-1:0];
      sync_q <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // shp_sync

`default_nettype wire

// [hdl/shp_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "shp_defs.vh"

module shp_top (
  input  wire       clock_in,
  input  wire       arst_n_in,
  input  wire       chip_select_n_in,
  input  wire       serial_clock_in,
  input  wire       serial_in_line_in,
  output wire       serial_out_line_out,
  output wire       serial_out_oe_n_out,
  input  wire       control_mode_select_in,
  output wire       host_mode_out,
  output wire [5:0] reg_addr_out,
  output wire       reg_rd_out,
  input  wire [7:0] reg_rdata_in,
  output wire [7:0] reg_wdata_out,
  output wire       reg_wr_out,
  input  wire [7:0] alarm_status_in,
  input  wire       global_irq_enable_in,
  output wire       irq_n_out,
  output wire       irq_oe_n_out
);

  // ========================================================================
  // Reset release.
  // ========================================================================
  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ========================================================================
  // Pin synchronisation and edge detection.
  // ========================================================================
  wire [3:0] pins_sync;
  reg        sclk_prev_q;

  shp_sync #(
    .WIDTH     (4),
    .RESET_VAL (`SHP_SYNC_RESET)
  ) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_q),
    .async_in ({chip_select_n_in, control_mode_select_in, serial_clock_in,
                serial_in_line_in}),
    .sync_out (pins_sync)
  );

  wire cs_n_s   = pins_sync[3];
  wire mode_s   = pins_sync[2];
  wire sclk_s   = pins_sync[1];
  wire sdi_s    = pins_sync[0];

  wire host_mode = ~mode_s;

  wire active   = host_mode & ~cs_n_s;
  wire sclk_ris = active & sclk_s & ~sclk_prev_q;
  wire sclk_fal = active & ~sclk_s & sclk_prev_q;

  // Starts at the clock's idle high level to match the synchroniser reset.
  always @(posedge clock_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sclk_prev_q <= 1'b1;
    else
      sclk_prev_q <= sclk_s;
  end

  // ========================================================================
  // Frame receive.
  // ========================================================================
  reg [4:0] bit_cnt_q;
  reg       rw_q;
  reg [5:0] addr_q;
  reg [7:0] wdata_q;
  reg       rd_q;
  reg       load_q;
  reg       wr_q;
  reg       status_rd_q;
  reg [7:0] shout_q;
  reg       sdo_q;
  reg       sdo_oe_n_q;

  function in_status;
    input [5:0] a;
    begin
      in_status = (a >= `SHP_STATUS_ADDR_LO) && (a <= `SHP_STATUS_ADDR_HI);
    end
  endfunction

  // Counting restarts whenever select is high, so an aborted frame
  // never leaves a partial write behind for the next access.
  always @(posedge clock_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bit_cnt_q   <= 5'd0;
      rw_q        <= 1'b0;
      addr_q      <= 6'h00;
      wdata_q     <= 8'h00;
      rd_q        <= 1'b0;
      wr_q        <= 1'b0;
      status_rd_q <= 1'b0;
    end
    else
    begin
      rd_q        <= 1'b0;
      wr_q        <= 1'b0;
      status_rd_q <= 1'b0;
      if (!active)
      begin
        bit_cnt_q <= 5'd0;
      end
      else if (sclk_ris && (bit_cnt_q < `SHP_FRAME_BITS))
      begin
        bit_cnt_q <= bit_cnt_q + 5'd1;
        if (bit_cnt_q == 5'd0)
          rw_q <= sdi_s;
        else if (bit_cnt_q <= `SHP_ADDR_LAST_BIT)
          addr_q <= {addr_q[4:0], sdi_s};
        else if (bit_cnt_q >= `SHP_DATA_FIRST_BIT)
          wdata_q <= {wdata_q[6:0], sdi_s};
        if ((bit_cnt_q == `SHP_ADDR_LAST_BIT) && (rw_q == `SHP_RW_READ))
          rd_q <= 1'b1;
        if (bit_cnt_q == `SHP_DATA_LAST_BIT)
        begin
          wr_q        <= (rw_q != `SHP_RW_READ);
          status_rd_q <= (rw_q == `SHP_RW_READ) && in_status(addr_q);
        end
      end
    end
  end

  // ========================================================================
  // Read data shift out.
  // ========================================================================
  // Data is loaded a cycle after the read strobe and leaves on falling
  // edges, so the host sees each bit stable at its next rising edge.
  always @(posedge clock_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      load_q     <= 1'b0;
      shout_q    <= 8'h00;
      sdo_q      <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end
    else
    begin
      load_q <= rd_q;
      if (!active)
        sdo_oe_n_q <= 1'b1;
      if (load_q)
        shout_q <= reg_rdata_in;
      else if (sclk_fal && (rw_q == `SHP_RW_READ) &&
               (bit_cnt_q >= `SHP_DATA_FIRST_BIT) &&
               (bit_cnt_q < `SHP_FRAME_BITS))
      begin
        sdo_q      <= shout_q[7];
        shout_q    <= {shout_q[6:0], 1'b0};
        sdo_oe_n_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Alarm interrupt.
  // ========================================================================
  reg [7:0] alarm_prev_q;
  reg       irq_pend_q;
  reg       irq_oe_n_q;

  wire alarm_change = |(alarm_status_in ^ alarm_prev_q);

  // A change landing on the acknowledging read keeps the interrupt pending.
  always @(posedge clock_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      alarm_prev_q <= 8'h00;
      irq_pend_q   <= 1'b0;
      irq_oe_n_q   <= 1'b1;
    end
    else
    begin
      alarm_prev_q <= alarm_status_in;
      if (alarm_change && global_irq_enable_in)
        irq_pend_q <= 1'b1;
      else if (status_rd_q)
        irq_pend_q <= 1'b0;
      irq_oe_n_q <= ~(irq_pend_q & global_irq_enable_in);
    end
  end

  // ========================================================================
  // Outputs.
  // ========================================================================
  assign serial_out_line_out = sdo_q;
  assign serial_out_oe_n_out = sdo_oe_n_q;
  assign host_mode_out       = host_mode;
  assign reg_addr_out        = addr_q;
  assign reg_rd_out          = rd_q;
  assign reg_wdata_out       = wdata_q;
  assign reg_wr_out          = wr_q;
  assign irq_n_out           = 1'b0;       // Open drain: only ever pulls low.
  assign irq_oe_n_out        = irq_oe_n_q;

endmodule // shp_top

`default_nettype wire

// [hdl/shp_unused_placeholder_none.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/shp_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ============
// Port checks of the serial host port.
module shp_top_asserts (
  input wire logic       clock_in,
  input wire logic       arst_n_in,
  input wire logic       chip_select_n_in,
  input wire logic       serial_clock_in,
  input wire logic       serial_out_line_out,
  input wire logic       serial_out_oe_n_out,
  input wire logic       control_mode_select_in,
  input wire logic       host_mode_out,
  input wire logic       reg_rd_out,
  input wire logic       reg_wr_out,
  input wire logic [7:0] alarm_status_in,
  input wire logic       global_irq_enable_in,
  input wire logic       irq_oe_n_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  // A lookup pulse is followed by the first read bit on the falling edge after the eighth clock rises.
  sequence s_lookup;
    reg_rd_out ##1 !reg_rd_out;
  endsequence
  sequence s_first_bit;
    ##[4:40] $fell(serial_out_oe_n_out);
  endsequence
  property p_rd_bit;
    s_lookup |-> s_first_bit;
  endproperty
  a_rd_bit: assert property (p_rd_bit) else $error("no read data");
  property p_req_sel;
    (reg_rd_out || reg_wr_out) |-> !chip_select_n_in && host_mode_out;
  endproperty
  a_req_sel: assert property (p_req_sel) else $error("request while idle");
  property p_out_fall;
    $changed(serial_out_line_out) && !serial_out_oe_n_out && !chip_select_n_in
      |-> !serial_clock_in;
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("data moved on rise");
  property p_wr_once;
    reg_wr_out |=> !reg_wr_out [*8];
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write repeated");
  property p_irq_set;
    $changed(alarm_status_in) && global_irq_enable_in
      |-> ##[1:4] (!irq_oe_n_out || !global_irq_enable_in);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("alarm not flagged");
  property p_irq_gate;
    !global_irq_enable_in ##1 !global_irq_enable_in |=> irq_oe_n_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("flag while disabled");
  property p_rst;
    $rose(arst_n_in) |-> irq_oe_n_out && serial_out_oe_n_out && !reg_rd_out && !reg_wr_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset");
  property p_mode;
    control_mode_select_in [*6] |-> !host_mode_out;
  endproperty
  a_mode: assert property (p_mode) else $error("host mode kept");
endmodule // shp_top_asserts
bind shp_top shp_top_asserts u_chk (.clock_in, .arst_n_in, .chip_select_n_in,
  .serial_clock_in, .serial_out_line_out, .serial_out_oe_n_out, .control_mode_select_in,
  .host_mode_out, .reg_rd_out, .reg_wr_out, .alarm_status_in, .global_irq_enable_in,
  .irq_oe_n_out);
`default_nettype wire

// [bench/shp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============
// Host side of the serial link.
module shp_host_model (
  input  wire logic sdo_in,
  input  wire logic oe_n_in,
  output var  logic cs_n_out = 1'b1,
  output var  logic sclk_out = 1'b1,
  output var  logic sdi_out  = 1'b0
);
  logic [7:0] rbyte;
  task automatic frame(input logic [15:0] w, input int n);
    cs_n_out = 1'b0;
    #100;
    for (int i = 0; i < n; i++)
    begin
      sclk_out = 1'b0;
      sdi_out  = w[15-i];
      #62.5;
      sclk_out = 1'b1;
      // A released output reads inverted, so a missing drive never passes.
      if (i > 7) rbyte[15-i] = oe_n_in ? ~sdo_in : sdo_in;
      #62.5;
    end
    cs_n_out = 1'b1;
    sdi_out  = ~sdi_out;
    #300;
  endtask
endmodule // shp_host_model
`default_nettype wire

// [bench/shp_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ============
// Bench for the serial host port.
module shp_top_bench;
  logic        clock_in = 1'b0, arst_n_in = 1'b0, control_mode_select_in = 1'b0;
  logic        global_irq_enable_in = 1'b0;
  logic [7:0]  reg_rdata_in = 8'h00, alarm_status_in = 8'h00, regs [64];
  wire         chip_select_n_in, serial_clock_in, serial_in_line_in, serial_out_line_out;
  wire         serial_out_oe_n_out, host_mode_out, reg_rd_out, reg_wr_out, irq_n_out;
  wire         irq_oe_n_out;
  wire  [5:0]  reg_addr_out;
  wire  [7:0]  reg_wdata_out;
  // The interrupt line has a pull-up, so it is high unless pulled.
  wire         irq_line = irq_oe_n_out | irq_n_out;
  logic [13:0] note_q [$];
  event        rd_seen;
  int          bad_count = 0, n_tests = 0;
  initial forever #5 clock_in = ~clock_in;
  shp_top u_dut (.clock_in, .arst_n_in, .chip_select_n_in, .serial_clock_in,
    .serial_in_line_in, .serial_out_line_out, .serial_out_oe_n_out, .control_mode_select_in,
    .host_mode_out, .reg_addr_out, .reg_rd_out, .reg_rdata_in, .reg_wdata_out, .reg_wr_out,
    .alarm_status_in, .global_irq_enable_in, .irq_n_out, .irq_oe_n_out);
  shp_host_model u_host (.sdo_in(serial_out_line_out), .oe_n_in(serial_out_oe_n_out),
    .cs_n_out(chip_select_n_in), .sclk_out(serial_clock_in), .sdi_out(serial_in_line_in));
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    if (seen !== exp) bad_count++;
  endtask
  function automatic logic [13:0] pop_note();
    if (note_q.size() == 0) return 'x;
    return note_q.pop_front();
  endfunction
  // Only whole frames in host mode leave a note; refused ones expect nothing.
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [7:0] d, input int n);
    logic live;
    live = n == 16 && !control_mode_select_in;
    if (live) note_q.push_back({a, rw ? regs[a] : d});
    u_host.frame({rw, a, 1'b0, d}, n);
    if (live && !rw) regs[a] = d;
    if (live && rw) -> rd_seen;
    @(negedge clock_in);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (3) @(negedge clock_in);
    chk({13'h0, irq_line}, {13'h0, exp});
  endtask
  // Register side answers lookups half a clock later, on each falling clock edge; the watchers compare results.
  always @(negedge clock_in) reg_rdata_in <= regs[reg_addr_out];
  always @(negedge clock_in)
    if (reg_wr_out === 1'b1) chk({reg_addr_out, reg_wdata_out}, pop_note());
  always @(rd_seen) chk({reg_addr_out, u_host.rbyte}, pop_note());
  initial
  begin
    logic [5:0] edge_addr [3] = '{6'h00, 6'h3f, 6'h15};
    void'($urandom(32'h517b));
    foreach (regs[i]) regs[i] = 8'($urandom);
    repeat (10) @(negedge clock_in);
    arst_n_in = 1'b1;
    repeat (8) @(negedge clock_in);
    // Back-to-back writes at the two end addresses and 6'h15, then reads of them.
    foreach (edge_addr[i]) xfer(1'b0, edge_addr[i], 8'($urandom), 16);
    foreach (edge_addr[i]) xfer(1'b1, edge_addr[i], 8'($urandom), 16);
    $display("test read_write done");
    // A cut-short write and hardware-mode frames must leave the registers alone.
    xfer(1'b0, 6'h01, 8'h5a, 10);
    control_mode_select_in = 1'b1;
    repeat (6) @(negedge clock_in);
    chk({13'h0, host_mode_out}, 14'h0);
    xfer(1'b0, 6'h02, 8'ha5, 16);
    xfer(1'b1, 6'h02, 8'h00, 16);
    control_mode_select_in = 1'b0;
    repeat (6) @(negedge clock_in);
    chk({13'h0, host_mode_out}, 14'h1);
    xfer(1'b1, 6'h01, 8'h00, 16);
    xfer(1'b1, 6'h02, 8'h00, 16);
    $display("test refused done");
    // Alarm change pulls the line, a status read frees it, disabled changes are quiet.
    global_irq_enable_in = 1'b1;
    alarm_status_in = alarm_status_in ^ (8'h01 | 8'($urandom));
    irq_chk(1'b0);
    xfer(1'b1, 6'h20, 8'h00, 16);
    irq_chk(1'b1);
    global_irq_enable_in = 1'b0;
    alarm_status_in = ~alarm_status_in;
    irq_chk(1'b1);
    // A change seen while disabled must not be left pending for later.
    global_irq_enable_in = 1'b1;
    irq_chk(1'b1);
    $display("test interrupt done");
    // A second reset mid-run, then the port must work again.
    arst_n_in = 1'b0;
    repeat (10) @(negedge clock_in);
    chk({reg_addr_out, reg_wdata_out}, 14'h0);
    arst_n_in = 1'b1;
    repeat (8) @(negedge clock_in);
    xfer(1'b1, 6'h3f, 8'h00, 16);
    $display("test reset done");
    end_sim(0);
  end
  // The run takes about 31 us; a hang is cut off well past that.
  initial #300000 end_sim(1);
  task automatic end_sim(input int extra);
    bad_count += extra;
    $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
endmodule // shp_top_bench
`default_nettype wire
